// file: src/pfsa_pkg.sv
// constants and helpers shared by the program flash self-access block
`default_nettype none
package pfsa_pkg;
  localparam int DATA_W = 14;
  localparam int ADDR_W = 13;
  localparam int INDEX_W = 12;
  localparam int WORDS = 4096;
  localparam int CAL_WORDS = 16;
  localparam int BLOCK_WORDS = 4;
  localparam int ROW_WORDS = 16;
  localparam int ROW_W = 8;
  localparam int REG_ADDR_W = 3;

  // register offsets
  localparam logic [2:0] OFF_DATA_LOW = 3'h0;
  localparam logic [2:0] OFF_ADDR_LOW = 3'h1;
  localparam logic [2:0] OFF_DATA_HIGH = 3'h2;
  localparam logic [2:0] OFF_ADDR_HIGH = 3'h3;
  localparam logic [2:0] OFF_CONTROL = 3'h4;
  localparam logic [2:0] OFF_UNLOCK = 3'h5;

  // control register fields, high register widths and zero read value
  localparam int BIT_TRIM_SEL = 6;
  localparam int BIT_ALLOW = 2;
  localparam int BIT_WR = 1;
  localparam int BIT_RD = 0;
  localparam logic [7:0] CTL_FIXED_ONES = 8'h80;
  localparam int DATA_HIGH_W = 6;
  localparam int ADDR_HIGH_W = 4;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // unlock keys, last word of a block and row erase offset
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [1:0] LAST_IN_BLOCK = 2'h3;
  localparam logic [3:0] ERASE_NIBBLE = 4'h3;

  // erased flash content and calibration fill
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;
  localparam logic [13:0] CAL_FILL = 14'h0000;

  // programming time
  localparam int PROG_TIME_NS = 4000000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;

  // guard field: protected upper bound (exclusive) of low region
  localparam logic [1:0] GUARD_NONE = 2'h3;
  localparam logic [1:0] GUARD_LOW = 2'h2;
  localparam logic [1:0] GUARD_HALF = 2'h1;
  localparam logic [12:0] GUARD_LOW_TOP = 13'h0200;
  localparam logic [12:0] GUARD_HALF_TOP = 13'h0800;

  typedef enum logic [1:0] {
    PFSA_IDLE = 2'b00,
    PFSA_READ = 2'b01,
    PFSA_PROG = 2'b10
  } pfsa_state_type;

  function automatic logic pfsa_guarded(input logic [12:0] addr, input logic [1:0] guard);
    logic hit;
    hit = 1'b1;
    if (guard == GUARD_NONE) begin
      hit = 1'b0;
    end else if (guard == GUARD_LOW) begin
      hit = addr < GUARD_LOW_TOP;
    end else if (guard == GUARD_HALF) begin
      hit = addr < GUARD_HALF_TOP;
    end
    return hit;
  endfunction : pfsa_guarded
endpackage : pfsa_pkg
`default_nettype wire

// file: src/pfsa_array_if.sv
// link between the sequencer and the flash word array
`default_nettype none
interface pfsa_array_if;
  logic [11:0] rd_index;
  logic cal_sel;
  logic [13:0] rd_word;
  logic erase_en;
  logic [7:0] erase_row;
  logic wr_en;
  logic [9:0] wr_block;
  logic [55:0] wr_words;
  modport seq (output rd_index, output cal_sel, input rd_word, output erase_en,
               output erase_row, output wr_en, output wr_block, output wr_words);
  modport arr (input rd_index, input cal_sel, output rd_word, input erase_en,
               input erase_row, input wr_en, input wr_block, input wr_words);
endinterface : pfsa_array_if
`default_nettype wire

// file: src/pfsa_array.sv
// program flash word array with calibration area, in flip-flops
`default_nettype none
module pfsa_array #(
  parameter int WORDS = pfsa_pkg::WORDS,
  parameter int CAL_WORDS = pfsa_pkg::CAL_WORDS
) (
  input wire logic sys_clk,
  input wire logic reset,
  pfsa_array_if.arr link
);
  logic [13:0] mem [WORDS];
  logic [13:0] cal_mem [CAL_WORDS];

  for (genvar i = 0; i < WORDS; i++) begin : g_word
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        mem[i] <= pfsa_pkg::ERASED_WORD;
      end else if (link.wr_en && link.wr_block == 10'(i / pfsa_pkg::BLOCK_WORDS)) begin
        mem[i] <= link.wr_words[(i % pfsa_pkg::BLOCK_WORDS) * pfsa_pkg::DATA_W +: 14];
      end else if (link.erase_en && link.erase_row == 8'(i / pfsa_pkg::ROW_WORDS)) begin
        mem[i] <= pfsa_pkg::ERASED_WORD;
      end
    end
  end

  // trim area is read-only from this side
  for (genvar c = 0; c < CAL_WORDS; c++) begin : g_cal
    assign cal_mem[c] = pfsa_pkg::CAL_FILL;
  end

  always_comb begin
    if (link.cal_sel) begin
      link.rd_word = cal_mem[link.rd_index[3:0]];
    end else begin
      link.rd_word = mem[link.rd_index];
    end
  end
endmodule : pfsa_array
`default_nettype wire

// file: src/pfsa_top.sv
// program flash self-access sequencer with its register port
`default_nettype none
module pfsa_top #(
  parameter int PROG_CYCLES = pfsa_pkg::PROG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] self_write_guard,
  input wire logic read_out_lock,
  output logic serial_programmer_deny,
  output logic fetch_skip,
  output logic core_halt
);
  pfsa_array_if link ();

  pfsa_array u_array (
    .sys_clk(sys_clk),
    .reset(reset),
    .link(link)
  );

  pfsa_pkg::pfsa_state_type state;
  logic [7:0] flash_data_low;
  logic [5:0] flash_data_high;
  logic [7:0] flash_address_low;
  logic [3:0] flash_address_high;
  logic trim_space_select;
  logic program_allow;
  logic rd_trig;
  logic wr_trig;
  logic key_first_seen;
  logic unlocked;
  logic [13:0] buffer [pfsa_pkg::BLOCK_WORDS];
  logic [31:0] prog_count;
  logic erase_needed;

  logic [12:0] flash_address;
  logic [13:0] data_word;
  logic wr_ctl;
  logic wr_request;
  logic wr_refused;

  assign flash_address = {1'b0, flash_address_high, flash_address_low};
  assign data_word = {flash_data_high, flash_data_low};
  assign wr_ctl = reg_wr && reg_addr == pfsa_pkg::OFF_CONTROL;
  assign wr_request = wr_trig && state == pfsa_pkg::PFSA_IDLE && !rd_trig;
  // code lock is not consulted here: the CPU keeps full access
  assign wr_refused = !program_allow || trim_space_select
                      || pfsa_pkg::pfsa_guarded(flash_address, self_write_guard);

  assign link.rd_index = flash_address[11:0];
  assign link.cal_sel = trim_space_select;

  // unlock port: two keys in back-to-back writes, any other write disarms
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      key_first_seen <= 1'b0;
      unlocked <= 1'b0;
    end else if (reg_wr) begin
      key_first_seen <= reg_addr == pfsa_pkg::OFF_UNLOCK && reg_wdata == pfsa_pkg::KEY_FIRST;
      unlocked <= key_first_seen && reg_addr == pfsa_pkg::OFF_UNLOCK
                  && reg_wdata == pfsa_pkg::KEY_SECOND;
    end
  end

  // control bits; software may only set the triggers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      program_allow <= 1'b0;
      trim_space_select <= 1'b0;
    end else if (wr_ctl) begin
      program_allow <= reg_wdata[pfsa_pkg::BIT_ALLOW];
      trim_space_select <= reg_wdata[pfsa_pkg::BIT_TRIM_SEL];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_trig <= 1'b0;
    end else if (wr_ctl && reg_wdata[pfsa_pkg::BIT_RD]) begin
      rd_trig <= 1'b1;
    end else if (state == pfsa_pkg::PFSA_READ) begin
      rd_trig <= 1'b0;
    end
  end

  // a program trigger without the key pair is dropped
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_trig <= 1'b0;
    end else if (wr_ctl && reg_wdata[pfsa_pkg::BIT_WR] && unlocked) begin
      wr_trig <= 1'b1;
    end else if (wr_request
                 && (wr_refused || flash_address_low[1:0] != pfsa_pkg::LAST_IN_BLOCK)) begin
      wr_trig <= 1'b0;
    end else if (state == pfsa_pkg::PFSA_PROG && prog_count == 32'(PROG_CYCLES - 1)) begin
      wr_trig <= 1'b0;
    end
  end

  // sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= pfsa_pkg::PFSA_IDLE;
    end else begin
      case (state)
        pfsa_pkg::PFSA_IDLE: begin
          if (rd_trig) begin
            state <= pfsa_pkg::PFSA_READ;
          end else if (wr_request && !wr_refused
                       && flash_address_low[1:0] == pfsa_pkg::LAST_IN_BLOCK) begin
            state <= pfsa_pkg::PFSA_PROG;
          end
        end
        pfsa_pkg::PFSA_READ: begin
          state <= pfsa_pkg::PFSA_IDLE;
        end
        pfsa_pkg::PFSA_PROG: begin
          if (prog_count == 32'(PROG_CYCLES - 1)) begin
            state <= pfsa_pkg::PFSA_IDLE;
          end
        end
        default: begin
          state <= pfsa_pkg::PFSA_IDLE;
        end
      endcase
    end
  end

  // programming timer, no software timing needed
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prog_count <= '0;
    end else if (state == pfsa_pkg::PFSA_PROG) begin
      prog_count <= prog_count + 32'd1;
    end else begin
      prog_count <= '0;
    end
  end

  // erase only when the trigger lands right after a row boundary
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      erase_needed <= 1'b0;
    end else if (state == pfsa_pkg::PFSA_IDLE) begin
      erase_needed <= flash_address_low[3:0] == pfsa_pkg::ERASE_NIBBLE;
    end
  end

  // write buffer: every accepted trigger latches its word
  for (genvar b = 0; b < pfsa_pkg::BLOCK_WORDS; b++) begin : g_buf
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        buffer[b] <= pfsa_pkg::ERASED_WORD;
      end else if (wr_request && !wr_refused && flash_address_low[1:0] == 2'(b)) begin
        buffer[b] <= data_word;
      end
    end
    assign link.wr_words[b * pfsa_pkg::DATA_W +: 14] = buffer[b];
  end

  // array strobes: erase at the first busy cycle, program at the last
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link.erase_en <= 1'b0;
      link.erase_row <= '0;
      link.wr_en <= 1'b0;
      link.wr_block <= '0;
    end else begin
      link.erase_en <= state == pfsa_pkg::PFSA_PROG && prog_count == '0 && erase_needed;
      link.erase_row <= flash_address[11:4];
      link.wr_en <= state == pfsa_pkg::PFSA_PROG && prog_count == 32'(PROG_CYCLES - 1);
      link.wr_block <= flash_address[11:2];
    end
  end

  // data and address registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flash_data_low <= '0;
      flash_data_high <= '0;
      flash_address_low <= '0;
      flash_address_high <= '0;
    end else if (state == pfsa_pkg::PFSA_READ) begin
      flash_data_low <= link.rd_word[7:0];
      flash_data_high <= link.rd_word[13:8];
    end else if (reg_wr && state == pfsa_pkg::PFSA_IDLE) begin
      if (reg_addr == pfsa_pkg::OFF_DATA_LOW) begin
        flash_data_low <= reg_wdata;
      end else if (reg_addr == pfsa_pkg::OFF_DATA_HIGH) begin
        flash_data_high <= reg_wdata[pfsa_pkg::DATA_HIGH_W-1:0];
      end else if (reg_addr == pfsa_pkg::OFF_ADDR_LOW) begin
        flash_address_low <= reg_wdata;
      end else if (reg_addr == pfsa_pkg::OFF_ADDR_HIGH) begin
        flash_address_high <= reg_wdata[pfsa_pkg::ADDR_HIGH_W-1:0];
      end
    end
  end

  // read port
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == pfsa_pkg::OFF_DATA_LOW) begin
        reg_rdata <= flash_data_low;
      end else if (reg_addr == pfsa_pkg::OFF_DATA_HIGH) begin
        reg_rdata <= {2'b00, flash_data_high};
      end else if (reg_addr == pfsa_pkg::OFF_ADDR_LOW) begin
        reg_rdata <= flash_address_low;
      end else if (reg_addr == pfsa_pkg::OFF_ADDR_HIGH) begin
        reg_rdata <= {4'b0000, flash_address_high};
      end else if (reg_addr == pfsa_pkg::OFF_CONTROL) begin
        reg_rdata <= pfsa_pkg::CTL_FIXED_ONES | {1'b0, trim_space_select, 3'b000,
                     program_allow, wr_trig, rd_trig};
      end else begin
        reg_rdata <= pfsa_pkg::ZERO_BYTE;
      end
    end else begin
      reg_rdata <= pfsa_pkg::ZERO_BYTE;
    end
  end

  // core-facing status
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      serial_programmer_deny <= 1'b0;
      fetch_skip <= 1'b0;
      core_halt <= 1'b0;
    end else begin
      serial_programmer_deny <= read_out_lock;
      fetch_skip <= state == pfsa_pkg::PFSA_IDLE && rd_trig;
      core_halt <= state == pfsa_pkg::PFSA_PROG
                   && prog_count != 32'(PROG_CYCLES - 1);
    end
  end

  // checks
  logic [31:0] halt_run;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      halt_run <= '0;
    end else if (core_halt) begin
      halt_run <= halt_run + 32'd1;
    end else begin
      halt_run <= '0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  rd_clear_a: assert property ($rose(rd_trig) |-> ##[1:2] !rd_trig)
    else $error("read trigger not cleared in time");
  read_load_a: assert property (state == pfsa_pkg::PFSA_READ |=>
    data_word == $past(link.rd_word))
    else $error("read word not loaded");
  addr_high_a: assert property (reg_rd && reg_addr == pfsa_pkg::OFF_ADDR_HIGH |=>
    reg_rdata[7:4] == 4'h0)
    else $error("address high top bits not zero");
  data_high_a: assert property (reg_rd && reg_addr == pfsa_pkg::OFF_DATA_HIGH |=>
    reg_rdata[7:6] == 2'h0)
    else $error("data high top bits not zero");
  ctl_layout_a: assert property (reg_rd && reg_addr == pfsa_pkg::OFF_CONTROL |=>
    reg_rdata[7] && reg_rdata[5:3] == 3'h0 && reg_rdata[2] == $past(program_allow))
    else $error("control layout wrong");
  unlock_zero_a: assert property (reg_rd && reg_addr == pfsa_pkg::OFF_UNLOCK |=>
    reg_rdata == 8'h00)
    else $error("unlock port read not zero");
  write_gate_a: assert property (link.wr_en |-> program_allow && !trim_space_select)
    else $error("program while writes inhibited");
  trig_hold_a: assert property (state == pfsa_pkg::PFSA_PROG && !link.wr_en |-> wr_trig)
    else $error("program trigger dropped early");
  halt_len_a: assert property (core_halt |-> halt_run < 32'(PROG_CYCLES))
    else $error("halt longer than program time");
  refuse_a: assert property (wr_request && wr_refused |=> !wr_trig
    && state == pfsa_pkg::PFSA_IDLE)
    else $error("refused trigger not cleared");
  lock_out_a: assert property (##1 serial_programmer_deny == $past(read_out_lock))
    else $error("serial lock not followed");

  read_seen_c: cover property (state == pfsa_pkg::PFSA_READ);
  erase_seen_c: cover property (link.erase_en);
  program_seen_c: cover property (link.wr_en);
  refuse_seen_c: cover property (wr_request && wr_refused);
endmodule : pfsa_top
`default_nettype wire

// file: verif/pfsa_flash_model.sv
// reference model of the program flash contents behind the sequencer
`default_nettype none
module pfsa_flash_model;
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] mem [4096];
  logic [13:0] wbuf [4];

  // whole user array starts erased
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = pfsa_pkg::ERASED_WORD;
  end

  // called only for accepted program requests, so refusals leave mem alone
  task automatic latch(input logic [12:0] a, input logic [13:0] d);
    wbuf[a[1:0]] = d;
    if (a[1:0] == pfsa_pkg::LAST_IN_BLOCK) begin
      if (a[3:0] == pfsa_pkg::ERASE_NIBBLE) begin
        for (int i = 0; i < 16; i++) begin
          mem[{a[11:4], i[3:0]}] = pfsa_pkg::ERASED_WORD;
        end
      end
      for (int i = 0; i < 4; i++) mem[{a[11:2], i[1:0]}] = wbuf[i];
    end
  endtask : latch
endmodule : pfsa_flash_model
`default_nettype wire

// file: verif/program_flash_self_access_tb.sv
// self-checking bench for the program flash self-access sequencer
`default_nettype none
module program_flash_self_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 20;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] self_write_guard = 2'h3;
  logic read_out_lock = 1'b0;
  logic serial_programmer_deny;
  logic fetch_skip;
  logic core_halt;
  logic halt_seen;
  logic [12:0] a;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;

  always #4 sys_clk = ~sys_clk;

  pfsa_top #(.PROG_CYCLES(PROG)) u_pfsa_top (
    .sys_clk(sys_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .self_write_guard(self_write_guard),
    .read_out_lock(read_out_lock),
    .serial_programmer_deny(serial_programmer_deny),
    .fetch_skip(fetch_skip),
    .core_halt(core_halt)
  );

  pfsa_flash_model u_pfsa_flash_model ();

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [2:0] ad, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rdc

  task automatic set_addr(input logic [12:0] ad);
    wr(pfsa_pkg::OFF_ADDR_HIGH, {4'h0, ad[11:8]});
    wr(pfsa_pkg::OFF_ADDR_LOW, ad[7:0]);
  endtask : set_addr

  task automatic rdw(input logic [12:0] ad, input logic [7:0] ctl, input logic [13:0] exp);
    set_addr(ad);
    wr(pfsa_pkg::OFF_CONTROL, ctl | 8'h01);
    @(posedge sys_clk);
    #1;
    chk({15'h0000, fetch_skip}, 16'h0001);
    @(posedge sys_clk);
    rdc(pfsa_pkg::OFF_DATA_LOW, exp[7:0]);
    rdc(pfsa_pkg::OFF_DATA_HIGH, {2'h0, exp[13:8]});
  endtask : rdw

  task automatic prog(input logic [12:0] ad, input logic [13:0] d, input logic [7:0] ctl,
                      input logic ok);
    set_addr(ad);
    wr(pfsa_pkg::OFF_DATA_LOW, d[7:0]);
    wr(pfsa_pkg::OFF_DATA_HIGH, {2'h0, d[13:8]});
    wr(pfsa_pkg::OFF_UNLOCK, pfsa_pkg::KEY_FIRST);
    wr(pfsa_pkg::OFF_UNLOCK, pfsa_pkg::KEY_SECOND);
    wr(pfsa_pkg::OFF_CONTROL, ctl);
    halt_seen = 1'b0;
    // long enough for a whole block cycle at the shortened count
    for (int i = 0; i < PROG + 10; i++) begin
      @(posedge sys_clk);
      #1;
      if (core_halt === 1'b1) halt_seen = 1'b1;
    end
    chk({15'h0000, halt_seen}, {15'h0000, ok & (ad[1:0] == 2'h3)});
    rdc(pfsa_pkg::OFF_CONTROL, (ctl | 8'h80) & 8'hFD);
    if (ok) u_pfsa_flash_model.latch(ad, d);
  endtask : prog

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(pfsa_pkg::OFF_CONTROL, 8'h80);
    rdc(pfsa_pkg::OFF_DATA_LOW, 8'h00);
    rdc(pfsa_pkg::OFF_UNLOCK, 8'h00);
    $display("test reset values done");
    wr(pfsa_pkg::OFF_ADDR_HIGH, 8'hFF);
    rdc(pfsa_pkg::OFF_ADDR_HIGH, 8'h0F);
    wr(pfsa_pkg::OFF_DATA_HIGH, 8'hFF);
    rdc(pfsa_pkg::OFF_DATA_HIGH, 8'h3F);
    wr(pfsa_pkg::OFF_ADDR_LOW, 8'hA5);
    rdc(pfsa_pkg::OFF_ADDR_LOW, 8'hA5);
    wr(pfsa_pkg::OFF_CONTROL, 8'h7E);
    rdc(pfsa_pkg::OFF_CONTROL, 8'hC4);
    wr(pfsa_pkg::OFF_UNLOCK, 8'h55);
    rdc(pfsa_pkg::OFF_UNLOCK, 8'h00);
    wr(3'h7, 8'hFF);
    rdc(3'h7, 8'h00);
    wr(pfsa_pkg::OFF_CONTROL, 8'h00);
    $display("test register fields done");
    read_out_lock <= 1'b1;
    rdw(13'h0ABC, 8'h00, pfsa_pkg::ERASED_WORD);
    chk({15'h0000, serial_programmer_deny}, 16'h0001);
    rdc(pfsa_pkg::OFF_CONTROL, 8'h80);
    rdw(13'h0005, 8'h40, pfsa_pkg::CAL_FILL);
    wr(pfsa_pkg::OFF_CONTROL, 8'h00);
    $display("test reads done");
    // second block lands on the erase offset and wipes the first
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 4; i++) begin
        a = 13'h0FF4 - 13'(4 * b) + 13'(i);
        prog(a, 14'h1234 + 14'(b * 16 + i), 8'h06, 1'b1);
      end
    end
    for (int i = 0; i < 16; i++) begin
      a = 13'h0FF0 + 13'(i);
      rdw(a, 8'h00, u_pfsa_flash_model.mem[a]);
    end
    $display("test block program done");
    read_out_lock <= 1'b0;
    // every guard code that covers the low region is tried, the all-blocking one last
    for (int c = 0; c < 5; c++) begin
      self_write_guard <= (c == 2) ? pfsa_pkg::GUARD_LOW : (c == 3) ? pfsa_pkg::GUARD_HALF
                        : (c == 4) ? 2'h0 : pfsa_pkg::GUARD_NONE;
      for (int i = 0; i < 4; i++) begin
        a = 13'h0100 + 13'(i);
        prog(a, 14'h0AAA, (c == 0) ? 8'h02 : (c == 1) ? 8'h46 : 8'h06, 1'b0);
      end
      wr(pfsa_pkg::OFF_CONTROL, 8'h00);
      rdw(13'h0103, 8'h00, pfsa_pkg::ERASED_WORD);
    end
    self_write_guard <= pfsa_pkg::GUARD_NONE;
    chk({15'h0000, serial_programmer_deny}, 16'h0000);
    $display("test refused programs done");
    conclude();
  end
endmodule : program_flash_self_access_tb
`default_nettype wire
